// [common/sewp_pkg.sv]
// package for the three-wire serial eeprom slave port
package sewp_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_MS = 1000000;
    localparam int SELECT_LOW_GAP_NS = 250;
    localparam int WORD_PROG_TIME_MS = 10;
    localparam int ERASE_ALL_TIME_MS = 15;
    localparam int WRITE_ALL_TIME_MS = 30;
    localparam int WORD_PROG_CYC = WORD_PROG_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int ERASE_ALL_CYC = ERASE_ALL_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int WRITE_ALL_CYC = WRITE_ALL_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int ADDR_BITS_X8 = 7;
    localparam int OPCODE_BITS = 2;
    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] EXT_DISABLE = 2'h0;
    localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
    localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
    localparam logic [1:0] EXT_ENABLE = 2'h3;
    localparam logic [15:0] ERASED_WORD = 16'hffff;

    typedef enum logic [2:0] {
        SEWP_IDLE = 3'h0,
        SEWP_OPCODE = 3'h1,
        SEWP_ADDR = 3'h2,
        SEWP_DATA = 3'h3,
        SEWP_READ = 3'h4,
        SEWP_DONE = 3'h5
    } sewp_state_t;

    typedef enum logic [1:0] {
        SEWP_PROG_WORD = 2'h0,
        SEWP_PROG_ERASE_ALL = 2'h1,
        SEWP_PROG_WRITE_ALL = 2'h2
    } sewp_prog_t;

    // sampled pin levels after synchronisation
    typedef struct packed {
        logic select;
        logic sclk;
        logic serial_in;
        logic word_width_select;
    } sewp_pins_t;

    // one access to the storage array
    typedef struct packed {
        logic wr_en;
        logic [7:0] addr;
        logic [15:0] wdata;
    } sewp_mem_req_t;
endpackage : sewp_pkg

// [src/sewp_mem.sv]
// storage array with registered read data
`timescale 1ns/1ps
module sewp_mem #(
    parameter int DEPTH = 128,
    parameter int AW = 8
) (
    input wire logic clk_sys,
    input wire sewp_pkg::sewp_mem_req_t req,
    output logic [15:0] rdata_q
);
    import sewp_pkg::*;
    logic [15:0] mem [DEPTH];

    // no reset on the array: contents are nonvolatile in spirit
    always_ff @(posedge clk_sys) begin
        if (req.wr_en) begin
            mem[req.addr[AW-1:0] % DEPTH] <= req.wdata;
        end
        rdata_q <= mem[req.addr[AW-1:0] % DEPTH];
    end
endmodule : sewp_mem

// [src/sewp_port.sv]
// three-wire serial eeprom slave port, x8 or x16 organisation
`timescale 1ns/1ps
module sewp_port #(
    parameter int WORD_PROG_CYCLES = sewp_pkg::WORD_PROG_CYC,
    parameter int ERASE_ALL_CYCLES = sewp_pkg::ERASE_ALL_CYC,
    parameter int WRITE_ALL_CYCLES = sewp_pkg::WRITE_ALL_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic chip_select,
    input wire logic sclk,
    input wire logic serial_in,
    input wire logic word_width_select,
    output logic serial_out_q,
    output logic serial_out_oe_n_q,
    output logic busy_q
);
    import sewp_pkg::*;

    localparam int WORDS8 = 1 << ADDR_BITS_X8;

    sewp_pins_t meta_q;
    sewp_pins_t pins_q;
    logic sclk_prev_q;
    logic sel_prev_q;
    sewp_state_t state_q;
    logic [4:0] cnt_q;
    logic [1:0] op_q;
    logic [7:0] addr_q;
    logic [15:0] data_q;
    logic [15:0] shift_q;
    logic x16_q;
    logic wr_enable_q;
    logic [31:0] prog_cnt_q;
    sewp_prog_t prog_kind_q;
    logic [7:0] prog_addr_q;
    logic [15:0] prog_data_q;
    logic status_arm_q;
    logic status_on_q;
    logic rd_pending_q;
    logic rd_load_q;
    sewp_mem_req_t mreq;
    logic [15:0] mem_rdata;

    logic rise;
    logic sel;
    logic sel_fall;
    logic sel_rise;
    logic [3:0] addr_len;
    logic [4:0] data_len;
    logic rd_hold;

    // address bits for the current organisation
    function automatic logic [3:0] addr_bits(input logic wide);
        addr_bits = wide ? 4'(ADDR_BITS_X8 - 1) : 4'(ADDR_BITS_X8);
    endfunction : addr_bits

    // two-flop synchroniser; only pins_q is read by logic
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            pins_q <= '0;
        end else begin
            meta_q <= {chip_select, sclk, serial_in, word_width_select};
            pins_q <= meta_q;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sclk_prev_q <= 1'b0;
            sel_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= pins_q.sclk;
            sel_prev_q <= pins_q.select;
        end
    end

    assign sel = pins_q.select;
    assign rise = sel && pins_q.sclk && !sclk_prev_q;
    // select edges seen in the same cycle as the synchroniser output changes
    assign sel_fall = sel_prev_q && !sel;
    assign sel_rise = !sel_prev_q && sel;
    assign addr_len = addr_bits(x16_q);
    assign data_len = x16_q ? 5'h10 : 5'h08;

    // instruction sequencer; held idle while deselected
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= SEWP_IDLE;
            cnt_q <= '0;
            op_q <= '0;
            addr_q <= '0;
            data_q <= '0;
            x16_q <= 1'b1;
            rd_pending_q <= 1'b0;
        end else if (!sel) begin
            state_q <= SEWP_IDLE;
            cnt_q <= '0;
            rd_pending_q <= 1'b0;
        end else begin
            rd_pending_q <= 1'b0;
            if (rise) begin
                case (state_q)
                    SEWP_IDLE: begin
                        // floating strap reads as high outside: x16
                        x16_q <= pins_q.word_width_select;
                        if (pins_q.serial_in && !busy_q) begin
                            state_q <= SEWP_OPCODE;
                            cnt_q <= '0;
                            // stale bits would alias x8 and x16 addresses
                            addr_q <= '0;
                        end
                    end
                    SEWP_OPCODE: begin
                        op_q <= {op_q[0], pins_q.serial_in};
                        cnt_q <= cnt_q + 5'h1;
                        if (cnt_q == 5'(OPCODE_BITS - 1)) begin
                            state_q <= SEWP_ADDR;
                            cnt_q <= '0;
                        end
                    end
                    SEWP_ADDR: begin
                        addr_q <= {addr_q[6:0], pins_q.serial_in};
                        cnt_q <= cnt_q + 5'h1;
                        if (cnt_q == 5'(addr_len - 4'h1)) begin
                            cnt_q <= '0;
                            if (op_q == OP_READ) begin
                                state_q <= SEWP_READ;
                                rd_pending_q <= 1'b1;
                            end else if (op_q == OP_WRITE ||
                                         (op_q == OP_EXT && addr_q[ADDR_BITS_X8-2:ADDR_BITS_X8-3]
                                          == EXT_WRITE_ALL && !x16_q) ||
                                         (op_q == OP_EXT && addr_q[ADDR_BITS_X8-3:ADDR_BITS_X8-4]
                                          == EXT_WRITE_ALL && x16_q)) begin
                                state_q <= SEWP_DATA;
                            end else begin
                                state_q <= SEWP_DONE;
                            end
                        end
                    end
                    SEWP_DATA: begin
                        data_q <= {data_q[14:0], pins_q.serial_in};
                        cnt_q <= cnt_q + 5'h1;
                        if (cnt_q == data_len - 5'h1) begin
                            state_q <= SEWP_DONE;
                        end
                    end
                    SEWP_READ: begin
                        // data count only; output shifting lives below
                        cnt_q <= cnt_q + 5'h1;
                        if (cnt_q == data_len - 5'h1) begin
                            state_q <= SEWP_DONE;
                        end
                    end
                    SEWP_DONE: state_q <= SEWP_DONE;
                    default: state_q <= SEWP_IDLE;
                endcase
            end
        end
    end

    // opcode field as seen by the decoder before the last address bit shifts in
    logic [1:0] ext_code;
    assign ext_code = x16_q ? addr_q[ADDR_BITS_X8-3:ADDR_BITS_X8-4]
                            : addr_q[ADDR_BITS_X8-2:ADDR_BITS_X8-3];

    logic exec_now;
    assign exec_now = sel && rise && (state_q == SEWP_DATA || state_q == SEWP_ADDR)
        && ((state_q == SEWP_DATA && cnt_q == data_len - 5'h1)
            || (state_q == SEWP_ADDR && cnt_q == 5'(addr_len - 4'h1)
                && op_q != OP_READ && op_q != OP_WRITE
                && !(op_q == OP_EXT && ext_code == EXT_WRITE_ALL)));

    // last read bit stands until select falls, not just one cycle
    assign rd_hold = state_q == SEWP_READ || (state_q == SEWP_DONE && op_q == OP_READ);

    // address including the bit on the wire this cycle
    logic [7:0] full_addr;
    logic [1:0] full_ext;
    assign full_addr = {addr_q[6:0], pins_q.serial_in};
    assign full_ext = x16_q ? full_addr[ADDR_BITS_X8-2 -: 2] : full_addr[ADDR_BITS_X8-1 -: 2];

    // self-timed programming engine, no serial clock needed
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= 1'b0;
            prog_cnt_q <= '0;
            prog_kind_q <= SEWP_PROG_WORD;
            prog_addr_q <= '0;
            prog_data_q <= '0;
            wr_enable_q <= 1'b0;
        end else if (busy_q) begin
            // runs regardless of select
            prog_cnt_q <= prog_cnt_q - 32'h1;
            if (prog_kind_q != SEWP_PROG_WORD) begin
                prog_addr_q <= prog_addr_q + 8'h1;
            end
            if (prog_cnt_q == 32'h1) begin
                busy_q <= 1'b0;
            end
        end else if (exec_now) begin
            if (state_q == SEWP_DATA) begin
                prog_data_q <= {data_q[14:0], pins_q.serial_in};
                busy_q <= wr_enable_q;
                prog_addr_q <= (op_q == OP_WRITE) ? addr_q : 8'h00;
                prog_kind_q <= (op_q == OP_WRITE) ? SEWP_PROG_WORD : SEWP_PROG_WRITE_ALL;
                prog_cnt_q <= (op_q == OP_WRITE) ? 32'(WORD_PROG_CYCLES)
                                                 : 32'(WRITE_ALL_CYCLES);
            end else if (op_q == OP_ERASE) begin
                busy_q <= wr_enable_q;
                prog_data_q <= ERASED_WORD;
                prog_addr_q <= full_addr;
                prog_kind_q <= SEWP_PROG_WORD;
                prog_cnt_q <= 32'(WORD_PROG_CYCLES);
            end else if (full_ext == EXT_ERASE_ALL) begin
                busy_q <= wr_enable_q;
                prog_data_q <= ERASED_WORD;
                prog_addr_q <= '0;
                prog_kind_q <= SEWP_PROG_ERASE_ALL;
                prog_cnt_q <= 32'(ERASE_ALL_CYCLES);
            end else begin
                wr_enable_q <= (full_ext == EXT_ENABLE);
            end
        end
    end

    // memory port: programming writes, else read address
    // reads share the port; none can start while busy
    always_comb begin
        mreq.wr_en = busy_q;
        mreq.addr = busy_q ? prog_addr_q : addr_q;
        mreq.wdata = prog_data_q;
        if (busy_q && !x16_q) begin
            mreq.wdata = {8'h00, prog_data_q[7:0]};
        end
    end

    sewp_mem #(.DEPTH(WORDS8 * 2), .AW(8)) u_mem (
        .clk_sys(clk_sys),
        .req(mreq),
        .rdata_q(mem_rdata)
    );

    // status is armed by programming start with select seen low then high
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            status_arm_q <= 1'b0;
            status_on_q <= 1'b0;
        end else begin
            if (sel_fall) begin
                status_on_q <= 1'b0;
                status_arm_q <= busy_q;
            end else if (sel_rise && (status_arm_q || busy_q)) begin
                status_on_q <= 1'b1;
                status_arm_q <= 1'b0;
            end else if (!busy_q && !sel) begin
                status_arm_q <= 1'b0;
            end
            if (status_on_q && rise) begin
                status_on_q <= 1'b0;
            end
        end
    end

    // array read data is registered: it lands one cycle after the address
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_load_q <= 1'b0;
        end else begin
            rd_load_q <= rd_pending_q;
        end
    end

    // output pin: read data, status, or released
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            serial_out_q <= 1'b1;
            serial_out_oe_n_q <= 1'b1;
            shift_q <= '0;
        end else if (!sel) begin
            serial_out_oe_n_q <= 1'b1;
            serial_out_q <= 1'b1;
        end else if (rd_pending_q) begin
            // dummy zero before the data word; array word not out yet
            serial_out_q <= 1'b0;
            serial_out_oe_n_q <= 1'b0;
        end else if (rd_load_q) begin
            // fine only while a link bit spans several system clocks
            shift_q <= x16_q ? mem_rdata : {mem_rdata[7:0], 8'h00};
        end else if (state_q == SEWP_READ && rise) begin
            serial_out_q <= shift_q[15];
            shift_q <= {shift_q[14:0], 1'b0};
            serial_out_oe_n_q <= 1'b0;
        end else if (status_on_q) begin
            serial_out_q <= !busy_q;
            serial_out_oe_n_q <= 1'b0;
        end else if (!rd_hold) begin
            serial_out_oe_n_q <= 1'b1;
        end
    end
endmodule : sewp_port

// [verification/sewp_master.sv]
// host model driving the port pins over the three-wire link
`timescale 1ns/1ps
module sewp_master (
    output logic chip_select,
    output logic sclk,
    output logic serial_in,
    input wire logic serial_out_q,
    input wire logic serial_out_oe_n_q
);
    logic do_last = 1'b0;
    logic do_wire;
    // released line shows the inverse, never a stale level
    assign do_wire = serial_out_oe_n_q ? ~do_last : serial_out_q;
    always @(serial_out_q or serial_out_oe_n_q) if (!serial_out_oe_n_q) do_last = serial_out_q;
    initial begin
        chip_select = 1'b0;
        sclk = 1'b0;
        serial_in = 1'b0;
    end
    // link clock only runs inside bit slots; whole count per call
    task automatic xfer(input int n, input logic [31:0] v, output logic [31:0] r,
        input int hold = 0);
        r = '0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = v[i];
            #62.5 sclk = 1'b1;
            #(62.5 + hold) r[i] = do_wire;
            sclk = 1'b0;
        end
    endtask : xfer
    task automatic select(input logic lvl);
        #20 chip_select = lvl;
        #260; // gap above 250 ns
    endtask : select
endmodule : sewp_master

// [verification/sewp_port_props.sv]
// pin-level assertions for the three-wire serial eeprom port
`timescale 1ns/1ps
module sewp_port_props #(
    parameter int WRITE_ALL_CYCLES = 300
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic chip_select,
    input wire logic sclk,
    input wire logic serial_in,
    input wire logic word_width_select,
    input wire logic serial_out_q,
    input wire logic serial_out_oe_n_q,
    input wire logic busy_q
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    int busy_len_q;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) busy_len_q <= 0;
        else busy_len_q <= busy_q ? busy_len_q + 1 : 0;
    end
    sequence cs_up_busy;
        $rose(chip_select) && busy_q;
    endsequence
    sequence status_low;
        !serial_out_oe_n_q && !serial_out_q;
    endsequence
    out_release_a: assert property ($fell(chip_select) |-> ##[1:4] serial_out_oe_n_q)
        else $error("output not released after deselect");
    standby_hiz_a: assert property (!chip_select [*6] |-> serial_out_oe_n_q)
        else $error("output driven while deselected");
    drive_sel_a: assert property ($fell(serial_out_oe_n_q) |-> $past(chip_select, 2))
        else $error("output enabled without select");
    busy_hold_a: assert property ($rose(busy_q) |-> busy_q [*8])
        else $error("programming cut short");
    busy_bound_a: assert property (busy_len_q <= WRITE_ALL_CYCLES)
        else $error("programming too long");
    status_show_a: assert property (cs_up_busy |-> ##[1:5] status_low)
        else $error("busy status not shown");
    status_busy_a: assert property (busy_q && !serial_out_oe_n_q ##1 busy_q |->
        $past(serial_out_q) == 1'b0)
        else $error("status high while busy");
    status_ready_a: assert property ($fell(busy_q) && !serial_out_oe_n_q
        |-> ##[0:2] serial_out_q)
        else $error("ready status missing");
    read_shift_a: assert property ($changed(serial_out_q) && !serial_out_oe_n_q
        && !$past(serial_out_oe_n_q) && !busy_q && !$past(busy_q, 4) |-> sclk)
        else $error("read bit moved without clock rise");
endmodule : sewp_port_props

// [verification/tb.sv]
// self-checking bench for the three-wire serial eeprom port
`timescale 1ns/1ps
module tb;
    import sewp_pkg::*;
    // short program times; whole-array sweeps need at least 256
    localparam int WPC = 150;
    localparam int EAC = 300;
    localparam int WAC = 400;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic chip_select;
    logic sclk;
    logic serial_in;
    logic word_width_select = 1'b0; // always driven, never floating
    logic serial_out_q;
    logic serial_out_oe_n_q;
    logic busy_q;
    logic [31:0] r;
    int errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int bcnt = 0;
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    sewp_port #(.WORD_PROG_CYCLES(WPC), .ERASE_ALL_CYCLES(EAC), .WRITE_ALL_CYCLES(WAC)) dut_u (
        .clk_sys(clk_sys), .arst_n(arst_n), .chip_select(chip_select), .sclk(sclk),
        .serial_in(serial_in), .word_width_select(word_width_select),
        .serial_out_q(serial_out_q), .serial_out_oe_n_q(serial_out_oe_n_q), .busy_q(busy_q));
    sewp_master master_u (.chip_select(chip_select), .sclk(sclk), .serial_in(serial_in),
        .serial_out_q(serial_out_q), .serial_out_oe_n_q(serial_out_oe_n_q));
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (busy_q === 1'b1) bcnt <= bcnt + 1;
        if (cyc == 40000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic inst(input int n, input logic [31:0] v);
        master_u.select(1'b1);
        master_u.xfer(n, v, r);
        master_u.select(1'b0);
    endtask : inst
    task automatic prog(input int n, input logic [31:0] v, input int lim, input bit poll);
        bcnt = 0;
        inst(n, v);
        chk("busy after deselect", 1, busy_q);
        if (poll) begin
            master_u.select(1'b1);
            chk("status busy", 0, master_u.do_wire);
        end
        for (int i = 0; i < 2000 && busy_q === 1'b1; i++) @(negedge clk_sys);
        chk("status shown", poll, serial_out_oe_n_q === 1'b0);
        chk("busy span", 1, bcnt > lim - 3 && bcnt <= lim + 1);
        if (poll) begin
            #30;
            chk("status ready", 1, master_u.do_wire);
            master_u.select(1'b0);
            chk("released", 1, serial_out_oe_n_q);
        end
    endtask : prog
    task automatic rd(input int n, input logic [31:0] cmd, input int dn, input logic [31:0] exp,
        input int hold);
        master_u.select(1'b1);
        master_u.xfer(n, cmd, r);
        chk("dummy bit", 0, r[0]);
        master_u.xfer(dn, 0, r, hold);
        chk("read data", exp, r);
        master_u.select(1'b0);
    endtask : rd
    task automatic s_deselect();
        master_u.xfer(10, 32'h3ff, r);
        chk("deselected", 1, busy_q === 1'b0 && serial_out_oe_n_q === 1'b1);
    endtask : s_deselect
    task automatic s_write();
        inst(10, {1'b1, OP_EXT, EXT_ENABLE, 5'h00});
        chk("enable hi-z", 1, serial_out_oe_n_q);
        prog(18, {1'b1, OP_WRITE, 7'h55, 8'ha5}, WPC, 1'b1);
        rd(15, {1'b1, OP_READ, 7'h55}, 8, 8'ha5, 500);
    endtask : s_write
    task automatic s_refuse();
        master_u.select(1'b1);
        master_u.xfer(12, {1'b1, OP_WRITE, 7'h55, 2'h3}, r);
        master_u.select(1'b0);
        chk("partial dropped", 0, busy_q);
        master_u.select(1'b1);
        master_u.xfer(10, {1'b1, OP_EXT, EXT_ENABLE, 5'h00}, r);
        master_u.xfer(18, {1'b1, OP_WRITE, 7'h55, 8'h0f}, r);
        master_u.select(1'b0);
        chk("tail ignored", 0, busy_q);
        rd(10, {1'b1, OP_READ, 7'h55}, 8, 8'ha5, 0);
    endtask : s_refuse
    task automatic s_whole();
        prog(10, {1'b1, OP_ERASE, 7'h55}, WPC, 1'b0);
        rd(10, {1'b1, OP_READ, 7'h55}, 8, 8'hff, 0);
        prog(18, {1'b1, OP_EXT, EXT_WRITE_ALL, 5'h00, 8'h3c}, WAC, 1'b0);
        rd(10, {1'b1, OP_READ, 7'h12}, 8, 8'h3c, 0);
        prog(10, {1'b1, OP_EXT, EXT_ERASE_ALL, 5'h00}, EAC, 1'b1);
        rd(10, {1'b1, OP_READ, 7'h12}, 8, 8'hff, 0);
    endtask : s_whole
    task automatic s_wide();
        word_width_select = 1'b1;
        prog(25, {1'b1, OP_WRITE, 6'h0a, 16'h1234}, WPC, 1'b1);
        rd(9, {1'b1, OP_READ, 6'h0a}, 16, 16'h1234, 0);
        word_width_select = 1'b0;
    endtask : s_wide
    task automatic s_disable();
        inst(10, {1'b1, OP_EXT, EXT_DISABLE, 5'h00});
        inst(18, {1'b1, OP_WRITE, 7'h55, 8'h77});
        chk("write refused", 0, busy_q);
        rd(10, {1'b1, OP_READ, 7'h55}, 8, 8'hff, 0);
    endtask : s_disable
    initial begin
        repeat (2) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        s_deselect();
        s_write();
        s_refuse();
        s_whole();
        s_wide();
        s_disable();
        report_and_stop();
    end
endmodule : tb
bind sewp_port sewp_port_props #(.WRITE_ALL_CYCLES(WRITE_ALL_CYCLES)) props_u (
    .clk_sys(clk_sys), .arst_n(arst_n), .chip_select(chip_select), .sclk(sclk),
    .serial_in(serial_in), .word_width_select(word_width_select), .serial_out_q(serial_out_q),
    .serial_out_oe_n_q(serial_out_oe_n_q), .busy_q(busy_q));
